// ---- rtl/prsl_pkg.sv ----
// Constants, types and helpers shared by the reset and strap latch design.
//
// What this block does
// [RL1] An internal power-on reset brings the block up with no external reset.
// [RL2] A hardware reset or a software reset request each reset the block.
// [RL3] The board holds the external reset pin low for at least 1 us.
// [RL4] Hardware reset restores defaults and recaptures straps like power-up.
// [RL5] Strap pin levels are sampled while reset is active and select modes.
// [RL6] A five-bit address comes from five pins; values 0 to 31 are legal.
// [RL7] Unstrapped address bits 4 to 1 read low and bit 0 reads high.
// [RL8] Collision, first LED, carrier, receive error pull up; others down.
// [RL9] Autonegotiation wakes on; a high duplex strap allows full duplex.
// [RL10] LED strap sets the link LED mode, default 1, also by register.
// [RL11] Crossover is on by default; an external pulldown turns it off.
// [RL12] The interface strap defaults low for MII; a pullup selects RMII.
// [RL13] After reset the strap pins return to their normal signal functions.
// [RL14] With RMII strapped, the board supplies a 50 MHz reference clock.
// [RL15] Internal reset ends about 200 us after external reset release.
// [RL16] Captured straps hold unchanged until the next hardware or power-on reset; a software reset keeps them.
package prsl_pkg;

  // ------------------------------------------------------------------
  // Timing.
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int HW_RESET_MIN_NS = 1000;
  localparam int HW_RESET_CYC =
    (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_RESET_US = 200;
  localparam int INT_RESET_CYC = INT_RESET_US * 1000 / CLK_PERIOD_NS;
  localparam int HOLD_MIN_CYC = 4;

  // ------------------------------------------------------------------
  // Strap pins.
  // ------------------------------------------------------------------
  localparam int NUM_STRAP = 9;
  localparam int PIN_COL = 0;
  localparam int PIN_RXD0 = 1;
  localparam int PIN_LINK_LED = 5;
  localparam int PIN_CRS = 6;
  localparam int PIN_RX_ER = 7;
  localparam int PIN_RX_DV = 8;
  localparam int ADDR_W = 5;
  localparam logic [NUM_STRAP-1:0] STRAP_PULLUP_MASK = 9'h0e1;
  localparam logic [NUM_STRAP-1:0] STRAP_DEFAULT = STRAP_PULLUP_MASK;

  // ------------------------------------------------------------------
  // Register map.
  // ------------------------------------------------------------------
  localparam int PADDR_W = 8;
  localparam logic [5:0] REG_PHY_CONTROL_REGISTER_IDX = 6'h19;
  localparam logic [5:0] REG_STRAP_IDX = 6'h1a;
  localparam logic [5:0] REG_RESET_IDX = 6'h1b;
  localparam logic [PADDR_W-1:0] ADDR_PHY_CONTROL_REGISTER = {REG_PHY_CONTROL_REGISTER_IDX, 2'b00};
  localparam logic [PADDR_W-1:0] ADDR_STRAP = {REG_STRAP_IDX, 2'b00};
  localparam logic [PADDR_W-1:0] ADDR_RESET = {REG_RESET_IDX, 2'b00};
  localparam int PHY_CONTROL_REGISTER_LED_LSB = 0;
  localparam int PHY_CONTROL_REGISTER_AN_BIT = 2;
  localparam int PHY_CONTROL_REGISTER_XO_BIT = 3;
  localparam int RESET_DONE_BIT = 0;
  localparam int RESET_SOFT_BIT = 15;
  localparam logic [1:0] LED_MODE_1 = 2'h1;
  localparam logic [1:0] LED_MODE_2 = 2'h2;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b11
  } prsl_state_e;

  function automatic logic [1:0] prsl_led_mode(input logic strap);
    prsl_led_mode = strap ? LED_MODE_1 : LED_MODE_2;
  endfunction

endpackage

// ---- rtl/prsl_strap_if.sv ----
// Interface between the reset core and the strap capture stage.
`timescale 1ns/1ns
interface prsl_strap_if;
  import prsl_pkg::*;
  logic [NUM_STRAP-1:0] pinRaw;
  logic extRstRaw_n;
  logic sampleEn;
  logic [NUM_STRAP-1:0] pinSync;
  logic extRstSync_n;
  logic [NUM_STRAP-1:0] strapVal;
  modport cap (input pinRaw, extRstRaw_n, sampleEn,
               output pinSync, extRstSync_n, strapVal);
  modport core (output pinRaw, extRstRaw_n, sampleEn,
                input pinSync, extRstSync_n, strapVal);
endinterface

// ---- rtl/prsl_strap_capture.sv ----
// Pin synchronisers and the strap capture register.
`timescale 1ns/1ns
module prsl_strap_capture (
  input wire logic clk,
  input wire logic arst_n,
  prsl_strap_if.cap sif
);
  import prsl_pkg::*;

  logic [NUM_STRAP-1:0] pinMeta_reg;
  logic [NUM_STRAP-1:0] pinSync_reg;
  logic rstMeta_reg;
  logic rstSync_reg;
  logic [NUM_STRAP-1:0] strap_reg;
  logic [NUM_STRAP-1:0] strap_next;

  // ------------------------------------------------------------------
  // Capture while sampling, hold otherwise.
  // ------------------------------------------------------------------
  always_comb begin
    strap_next = strap_reg;
    if (sif.sampleEn) begin
      strap_next = pinSync_reg; // [RL5] [RL16]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_reg <= STRAP_DEFAULT;
      pinSync_reg <= STRAP_DEFAULT;
      rstMeta_reg <= 1'b1;
      rstSync_reg <= 1'b1;
      strap_reg <= STRAP_DEFAULT;
    end else begin
      pinMeta_reg <= sif.pinRaw;
      pinSync_reg <= pinMeta_reg;
      rstMeta_reg <= sif.extRstRaw_n;
      rstSync_reg <= rstMeta_reg;
      strap_reg <= strap_next;
    end
  end

  assign sif.pinSync = pinSync_reg;
  assign sif.extRstSync_n = rstSync_reg;
  assign sif.strapVal = strap_reg;

endmodule // prsl_strap_capture

// ---- rtl/prsl_phy_reset_strap_latch.sv ----
// Reset sequencer, strap latch, pin release and APB registers.
`timescale 1ns/1ns
module prsl_phy_reset_strap_latch #(
  parameter int INT_RESET_CYC = prsl_pkg::INT_RESET_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic extResetPin_n,
  input wire logic [prsl_pkg::NUM_STRAP-1:0] strapPinIn,
  input wire logic [prsl_pkg::NUM_STRAP-1:0] funcOut,
  input wire logic [prsl_pkg::NUM_STRAP-1:0] funcOe,
  output logic [prsl_pkg::NUM_STRAP-1:0] strapPinOut,
  output logic [prsl_pkg::NUM_STRAP-1:0] strapPinOe,
  output logic [prsl_pkg::NUM_STRAP-1:0] pullUpSel,
  output logic pullEn,
  output logic [prsl_pkg::ADDR_W-1:0] phyAddress,
  output logic autonegEnable,
  output logic fullDuplexAllowed,
  output logic [1:0] ledMode,
  output logic crossoverEnable,
  output logic rmiiMode,
  output logic resetDone,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [prsl_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import prsl_pkg::*;

  if (INT_RESET_CYC < 1 || INT_RESET_CYC >= 65536) begin : g_chk
    $error("INT_RESET_CYC out of range");
  end

  localparam logic [5:0] HW_CYC = 6'(HW_RESET_CYC);
  localparam logic [2:0] HOLD_CYC = 3'(HOLD_MIN_CYC);
  localparam logic [15:0] WAIT_LAST = 16'(INT_RESET_CYC - 1);

  prsl_strap_if sif ();

  prsl_strap_capture u_cap (
    .clk(clk),
    .arst_n(arst_n),
    .sif(sif)
  );

  assign sif.pinRaw = strapPinIn;
  assign sif.extRstRaw_n = extResetPin_n;

  // ------------------------------------------------------------------
  // Hardware reset qualification.
  // ------------------------------------------------------------------
  logic [5:0] lowCnt_reg;
  logic [5:0] lowCnt_next;
  logic hwRst;

  always_comb begin
    lowCnt_next = 6'h00;
    if (!sif.extRstSync_n) begin
      lowCnt_next = (lowCnt_reg == HW_CYC) ? lowCnt_reg : lowCnt_reg + 6'h01;
    end
  end

  assign hwRst = (lowCnt_reg == HW_CYC); // [RL3]

  // ------------------------------------------------------------------
  // Reset sequencer.
  // ------------------------------------------------------------------
  prsl_state_e state_reg;
  prsl_state_e state_next;
  logic [2:0] holdCnt_reg;
  logic [2:0] holdCnt_next;
  logic [15:0] waitCnt_reg;
  logic [15:0] waitCnt_next;
  logic softReq;

  always_comb begin
    state_next = state_reg;
    holdCnt_next = 3'h0;
    waitCnt_next = 16'h0000;
    unique case (state_reg)
      ST_HOLD: begin
        holdCnt_next = (holdCnt_reg == HOLD_CYC) ? holdCnt_reg
                                                 : holdCnt_reg + 3'h1;
        if (!sif.extRstSync_n) begin
          holdCnt_next = 3'h0;
        end else if (holdCnt_reg == HOLD_CYC) begin
          state_next = ST_WAIT; // [RL1] [RL16]
        end
      end
      ST_WAIT: begin
        waitCnt_next = waitCnt_reg + 16'h0001;
        if (hwRst) begin
          state_next = ST_HOLD; // [RL2] [RL4]
        end else if (waitCnt_reg == WAIT_LAST) begin
          state_next = ST_RUN; // [RL15]
        end
      end
      ST_RUN: begin
        if (hwRst) begin
          state_next = ST_HOLD; // [RL2] [RL4]
        end else if (softReq) begin
          state_next = ST_WAIT; // [RL2]
        end
      end
      default: begin
        state_next = ST_HOLD;
      end
    endcase
  end

  assign sif.sampleEn = (state_reg == ST_HOLD); // [RL5]

  // ------------------------------------------------------------------
  // Control register and APB slave.
  // ------------------------------------------------------------------
  logic [1:0] ledMode_reg;
  logic [1:0] ledMode_next;
  logic autoneg_reg;
  logic autoneg_next;
  logic xo_reg;
  logic xo_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic setup;
  logic wrAcc;
  logic hit;
  logic [NUM_STRAP-1:0] strap;

  assign strap = sif.strapVal;
  assign setup = psel && !penable;
  assign wrAcc = psel && penable && pwrite;
  assign hit = (paddr == ADDR_PHY_CONTROL_REGISTER) || (paddr == ADDR_STRAP)
            || (paddr == ADDR_RESET);
  assign softReq = wrAcc && (paddr == ADDR_RESET) && pwdata[RESET_SOFT_BIT];

  always_comb begin
    ledMode_next = ledMode_reg;
    autoneg_next = autoneg_reg;
    xo_next = xo_reg;
    if (state_reg == ST_HOLD || (softReq && state_reg == ST_RUN)) begin
      ledMode_next = prsl_led_mode(sif.pinSync[PIN_CRS]); // [RL10] [RL4]
      autoneg_next = 1'b1; // [RL9]
      xo_next = sif.pinSync[PIN_RX_ER]; // [RL11]
      if (state_reg != ST_HOLD) begin
        ledMode_next = prsl_led_mode(strap[PIN_CRS]);
        xo_next = strap[PIN_RX_ER];
      end
    end else if (wrAcc && paddr == ADDR_PHY_CONTROL_REGISTER) begin
      ledMode_next = pwdata[PHY_CONTROL_REGISTER_LED_LSB +: 2]; // [RL10]
      autoneg_next = pwdata[PHY_CONTROL_REGISTER_AN_BIT];
      xo_next = pwdata[PHY_CONTROL_REGISTER_XO_BIT];
    end
  end

  always_comb begin
    prdata_next = prdata_reg;
    if (setup) begin
      prdata_next = 32'h0000_0000;
      if (paddr == ADDR_PHY_CONTROL_REGISTER) begin
        prdata_next[PHY_CONTROL_REGISTER_LED_LSB +: 2] = ledMode_reg;
        prdata_next[PHY_CONTROL_REGISTER_AN_BIT] = autoneg_reg;
        prdata_next[PHY_CONTROL_REGISTER_XO_BIT] = xo_reg;
      end else if (paddr == ADDR_STRAP) begin
        prdata_next[NUM_STRAP-1:0] = strap;
      end else if (paddr == ADDR_RESET) begin
        prdata_next[RESET_DONE_BIT] = (state_reg == ST_RUN);
      end
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_reg;

  // ------------------------------------------------------------------
  // Pin release.
  // ------------------------------------------------------------------
  logic [NUM_STRAP-1:0] pinOut_reg;
  logic [NUM_STRAP-1:0] pinOut_next;
  logic [NUM_STRAP-1:0] pinOe_reg;
  logic [NUM_STRAP-1:0] pinOe_next;
  logic pullEn_reg;
  logic pullEn_next;
  logic done_reg;
  logic done_next;

  always_comb begin
    pinOut_next = funcOut;
    pinOe_next = {NUM_STRAP{1'b0}};
    if (state_reg == ST_RUN) begin
      pinOe_next = funcOe; // [RL13]
    end
    pullEn_next = (state_next == ST_HOLD); // [RL7] [RL8]
    done_next = (state_next == ST_RUN);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lowCnt_reg <= 6'h00;
      state_reg <= ST_HOLD;
      holdCnt_reg <= 3'h0;
      waitCnt_reg <= 16'h0000;
      ledMode_reg <= LED_MODE_1;
      autoneg_reg <= 1'b1;
      xo_reg <= 1'b1;
      prdata_reg <= 32'h0000_0000;
      pinOut_reg <= {NUM_STRAP{1'b0}};
      pinOe_reg <= {NUM_STRAP{1'b0}};
      pullEn_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      lowCnt_reg <= lowCnt_next;
      state_reg <= state_next;
      holdCnt_reg <= holdCnt_next;
      waitCnt_reg <= waitCnt_next;
      ledMode_reg <= ledMode_next;
      autoneg_reg <= autoneg_next;
      xo_reg <= xo_next;
      prdata_reg <= prdata_next;
      pinOut_reg <= pinOut_next;
      pinOe_reg <= pinOe_next;
      pullEn_reg <= pullEn_next;
      done_reg <= done_next;
    end
  end

  assign strapPinOut = pinOut_reg;
  assign strapPinOe = pinOe_reg;
  assign pullUpSel = STRAP_PULLUP_MASK; // [RL7] [RL8]
  assign pullEn = pullEn_reg;
  assign phyAddress = strap[PIN_RXD0 +: 4] == 4'h0 && !strap[PIN_COL]
                    ? 5'h00 : {strap[PIN_RXD0 +: 4], strap[PIN_COL]}; // [RL6]
  assign fullDuplexAllowed = strap[PIN_LINK_LED]; // [RL9]
  assign rmiiMode = strap[PIN_RX_DV]; // [RL12] [RL14]
  assign autonegEnable = autoneg_reg;
  assign ledMode = ledMode_reg;
  assign crossoverEnable = xo_reg;
  assign resetDone = done_reg;

  // ------------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_hw_reset_entry: assert property (hwRst |=> state_reg == ST_HOLD) // [RL4]
    else $error("hardware reset did not enter hold");
  a_strap_frozen: assert property ( // [RL16]
    state_reg != ST_HOLD && $past(state_reg) != ST_HOLD |-> $stable(strap))
    else $error("strap value changed outside reset");
  a_pins_released: assert property ( // [RL13]
    state_reg == ST_RUN |=> strapPinOe == $past(funcOe))
    else $error("pins not returned to normal function");
  a_pins_quiet: assert property ( // [RL5]
    state_reg != ST_RUN |=> strapPinOe == '0)
    else $error("pin driven during reset");
  a_wait_length: assert property ( // [RL15]
    state_reg == ST_RUN && $past(state_reg) == ST_WAIT
    |-> $past(waitCnt_reg) == WAIT_LAST)
    else $error("internal reset length wrong");
  a_soft_reset: assert property ( // [RL2]
    softReq && state_reg == ST_RUN && !hwRst |=> state_reg == ST_WAIT
    && ledMode == prsl_led_mode(strap[PIN_CRS]) && autonegEnable)
    else $error("software reset not performed");
  a_addr_capture: assert property ( // [RL6]
    state_reg == ST_HOLD ##1 state_reg == ST_WAIT
    |-> {strap[PIN_RXD0 +: 4], strap[PIN_COL]} == phyAddress
        && strap == $past(sif.pinSync))
    else $error("address strap not captured");
  a_mode_defaults: assert property ( // [RL9]
    state_reg == ST_HOLD ##1 state_reg == ST_WAIT
    |-> autonegEnable && xo_reg == strap[PIN_RX_ER]
        && ledMode == prsl_led_mode(strap[PIN_CRS]))
    else $error("mode defaults not loaded from straps");
  a_hw_filter: assert property ( // [RL3]
    $rose(hwRst) |-> $past(!sif.extRstSync_n, 2))
    else $error("reset accepted without low pin");
  a_pull_in_hold: assert property ( // [RL8]
    pullEn == (state_reg == ST_HOLD))
    else $error("internal pulls not tied to hold state");
  a_done_in_run: assert property ( // [RL15]
    resetDone == (state_reg == ST_RUN))
    else $error("done flag does not match run state");
  a_hold_exit: assert property ( // [RL1]
    state_reg == ST_HOLD && sif.extRstSync_n && holdCnt_reg == HOLD_CYC
    |=> state_reg == ST_WAIT)
    else $error("hold state not left after power-on");
  a_phy_control_register_write: assert property ( // [RL10]
    wrAcc && paddr == ADDR_PHY_CONTROL_REGISTER && state_reg != ST_HOLD
    |=> ledMode == $past(pwdata[PHY_CONTROL_REGISTER_LED_LSB +: 2])
        && autonegEnable == $past(pwdata[PHY_CONTROL_REGISTER_AN_BIT]))
    else $error("control register write lost");

  c_hold_exit: cover property (state_reg == ST_HOLD ##1 state_reg == ST_WAIT);
  c_run_reach: cover property (state_reg == ST_WAIT ##1 state_reg == ST_RUN);
  c_soft_reset: cover property (softReq && state_reg == ST_RUN);
  c_rmii: cover property (state_reg == ST_RUN && rmiiMode);
  c_hw_reset: cover property ($rose(hwRst));

endmodule // prsl_phy_reset_strap_latch

// ---- tb/prsl_board_model.sv ----
// Board side of the strap pins: external resistors, weak pulls, pin drive.
`timescale 1ns/1ns
module prsl_board_model (
  input wire logic clk,
  input wire logic [prsl_pkg::NUM_STRAP-1:0] fitMask,
  input wire logic [prsl_pkg::NUM_STRAP-1:0] fitVal,
  input wire logic [prsl_pkg::NUM_STRAP-1:0] pinOut,
  input wire logic [prsl_pkg::NUM_STRAP-1:0] pinOe,
  input wire logic [prsl_pkg::NUM_STRAP-1:0] pullUpSel,
  input wire logic pullEn,
  output logic [prsl_pkg::NUM_STRAP-1:0] pinLevel
);
  import prsl_pkg::*;
  logic floatBit = 1'b0;
  // ------------------------------------------------------------------
  // Pin level: device drive beats resistor, resistor beats weak pull.
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    floatBit <= ~floatBit;
  end
  always_comb begin
    for (int i = 0; i < NUM_STRAP; i++) begin
      if (pinOe[i]) begin
        pinLevel[i] = pinOut[i];
      end else if (fitMask[i]) begin
        pinLevel[i] = fitVal[i];
      end else if (pullEn) begin
        pinLevel[i] = pullUpSel[i];
      end else begin
        pinLevel[i] = floatBit;
      end
    end
  end
endmodule // prsl_board_model

// ---- tb/prsl_phy_reset_strap_latch_tb.sv ----
// Self-checking testbench of the reset and strap latch block.
`timescale 1ns/1ns
module prsl_phy_reset_strap_latch_tb;
  import prsl_pkg::*;
  localparam int P = 20;
  localparam logic [8:0] PULL_UP = 9'b011100001;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic extResetPin_n = 1'b1;
  logic [8:0] strapPinIn, funcOut = '0, funcOe = '0, fitMask = '0;
  logic [8:0] fitVal = '0, strapPinOut, strapPinOe, pullUpSel, s;
  logic pullEn, autonegEnable, fullDuplexAllowed, crossoverEnable;
  logic rmiiMode, resetDone, pready, pslverr, err;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [4:0] phyAddress;
  logic [1:0] ledMode;
  logic [31:0] pwdata = '0, prdata, rd;
  int errors = 0, checked = 0, cycles = 0, n, seed = 85090;

  prsl_phy_reset_strap_latch #(.INT_RESET_CYC(P)) uut (.clk(clk),
    .arst_n(arst_n), .extResetPin_n(extResetPin_n),
    .strapPinIn(strapPinIn), .funcOut(funcOut), .funcOe(funcOe),
    .strapPinOut(strapPinOut), .strapPinOe(strapPinOe),
    .pullUpSel(pullUpSel), .pullEn(pullEn), .phyAddress(phyAddress),
    .autonegEnable(autonegEnable), .fullDuplexAllowed(fullDuplexAllowed),
    .ledMode(ledMode), .crossoverEnable(crossoverEnable),
    .rmiiMode(rmiiMode), .resetDone(resetDone), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  prsl_board_model board (.clk(clk), .fitMask(fitMask), .fitVal(fitVal),
    .pinOut(strapPinOut), .pinOe(strapPinOe), .pullUpSel(pullUpSel),
    .pullEn(pullEn), .pinLevel(strapPinIn));

  always #10 clk = ~clk;
  // ------------------------------------------------------------------
  // Tasks and expectations.
  // ------------------------------------------------------------------
  task automatic stop_test();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [3:0] phycrOf(input logic [8:0] v);
    phycrOf = {v[7], 1'b1, v[6] ? 2'h1 : 2'h2};
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitDone();
    n = 0;
    while (resetDone !== 1'b1) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic hwReset(input int len);
    @(posedge clk);
    extResetPin_n <= 1'b0;
    repeat (len) @(posedge clk);
    extResetPin_n <= 1'b1;
  endtask
  task automatic checkOut(input logic [8:0] v);
    chk(phyAddress, v[4:0]);
    chk(fullDuplexAllowed, v[5]);
    chk(autonegEnable, 1'b1);
    chk(ledMode, v[6] ? 2'h1 : 2'h2);
    chk(crossoverEnable, v[7]);
    chk(rmiiMode, v[8]);
    apb(1'b0, ADDR_STRAP, '0);
    chk(rd[8:0], v);
    apb(1'b0, ADDR_PHY_CONTROL_REGISTER, '0);
    chk(rd[3:0], phycrOf(v));
  endtask
  // ------------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    waitDone();
    chk(pullUpSel, PULL_UP);
    chk(n >= P, 1'b1);
    checkOut(PULL_UP);
    fitMask <= 9'h1ff;
    for (int i = 0; i < 6; i++) begin
      s = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : 9'($random(seed));
      fitVal <= s;
      hwReset(60);
      repeat (3) @(posedge clk);
      chk({resetDone, pullEn, strapPinOe}, {2'b01, 9'h000});
      waitDone();
      chk(n >= P && n < P + 20, 1'b1);
      fitVal <= ~s;
      repeat (5) @(posedge clk);
      checkOut(s);
    end
    fitVal <= s;
    hwReset(20);
    repeat (10) @(posedge clk);
    chk(resetDone, 1'b1);
    apb(1'b1, ADDR_PHY_CONTROL_REGISTER, 32'h2);
    apb(1'b0, ADDR_PHY_CONTROL_REGISTER, '0);
    chk(rd[3:0], 4'h2);
    chk({autonegEnable, ledMode}, 3'h2);
    apb(1'b1, ADDR_STRAP, '0);
    apb(1'b0, ADDR_STRAP, '0);
    chk(rd[8:0], s);
    apb(1'b1, ADDR_RESET, 32'h8000);
    repeat (3) @(posedge clk);
    chk(resetDone, 1'b0);
    waitDone();
    apb(1'b0, ADDR_PHY_CONTROL_REGISTER, '0);
    chk(rd[3:0], phycrOf(s));
    apb(1'b0, 8'h00, '0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      funcOe <= 9'($random(seed));
      funcOut <= 9'($random(seed));
      repeat (2) @(posedge clk);
      chk({pullEn, strapPinOe, strapPinOut}, {1'b0, funcOe, funcOut});
    end
    funcOe <= '0;
    stop_test();
  end
endmodule // prsl_phy_reset_strap_latch_tb
